// ### logic/ccd_pkg.sv
// Shared constants and types of the clear, call and decrement execution core
package ccd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB slave
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_ACC = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_PC = 8'h0C;
   localparam logic [7:0] OFF_LATCH = 8'h10;
   localparam logic [7:0] OFF_FADDR = 8'h14;
   localparam logic [7:0] OFF_FDATA = 8'h18;
   localparam logic [7:0] OFF_STACK = 8'h1C;
   localparam logic [7:0] OFF_WDT = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Status bit positions
   localparam int unsigned ST_C = 0;
   localparam int unsigned ST_DC = 1;
   localparam int unsigned ST_Z = 2;
   localparam int unsigned ST_POWER_DOWN = 3;
   localparam int unsigned ST_DOG_EXPIRY = 4;
   localparam int unsigned ST_W = 5;

   // Other field widths and positions
   localparam int unsigned PC_W = 13;
   localparam int unsigned K_W = 11;
   localparam int unsigned LATCH_W = 5;
   localparam int unsigned LATCH_HI = 4;
   localparam int unsigned LATCH_LO = 3;
   localparam int unsigned F_W = 7;
   localparam int unsigned D_BIT = 7;
   localparam int unsigned STACK_SP_LSB = 16;
   localparam int unsigned WDT_PRESC_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and prescaler wrap value
   localparam logic [4:0] STATUS_RST = 5'h18;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [7:0] PRESC_MAX = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction encodings of the 14-bit word
   localparam logic [13:0] OPC_KICK = 14'h0064;
   localparam logic [6:0] OPC_ZACC_HI = 7'h02;
   localparam logic [6:0] OPC_ZFILE_HI = 7'h03;
   localparam logic [2:0] OPC_CALL_HI = 3'h4;
   localparam logic [5:0] OPC_INV_HI = 6'h09;
   localparam logic [5:0] OPC_DEC_HI = 6'h03;
   localparam logic [5:0] OPC_DSKIP_HI = 6'h0B;

   // Decoded operations
   typedef enum logic [2:0] {
      OP_NOP, OP_KICK, OP_CALL, OP_INV, OP_ZFILE, OP_ZACC, OP_DEC, OP_DSKIP
   } ccd_op_e;

   // Execution states
   typedef enum logic {ST_RUN, ST_BUBBLE} ccd_state_e;

endpackage

// ### logic/ccd_alu_if.sv
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/10ps
`default_nettype none
interface ccd_alu_if;
   import ccd_pkg::*;
   ccd_op_e kind;
   logic [7:0] operand;
   logic [7:0] result;
   logic zero;
   modport core (output kind, output operand, input result, input zero);
   modport alu (input kind, input operand, output result, output zero);
endinterface
`default_nettype wire

// ### logic/ccd_alu.sv
// Arithmetic unit: complement and decrement of a file byte
`timescale 1ns/10ps
`default_nettype none
module ccd_alu (
   ccd_alu_if.alu bus
);
   import ccd_pkg::*;

   // Result and zero test
   always_comb begin
      case (bus.kind)
         OP_INV: bus.result = ~bus.operand; // RULE_06
         OP_DEC, OP_DSKIP: bus.result = bus.operand - 8'h01; // RULE_09
         default: bus.result = 8'h00;
      endcase
      bus.zero = (bus.result == 8'h00);
   end
endmodule
`default_nettype wire

// ### logic/ccd_core.sv
// Execution core for watchdog kick, call, invert, clear and decrement, with APB slave
//
// Behaviour
// RULE_01: Kick zeroes watchdog count and prescaler
// RULE_02: Kick sets expiry and power-down flags
// RULE_03: Call pushes program counter plus one
// RULE_04: Call loads eleven-bit target into low bits
// RULE_05: Call takes high bits from latch; two cycles
// RULE_06: Invert file byte, route by destination, zero flag
// RULE_07: Zero file clears byte, sets zero flag
// RULE_08: Zero accumulator clears it, sets zero flag
// RULE_09: Decrement file byte, route, update zero flag
// RULE_10: Decrement-skip routes result, flags untouched
// RULE_11: Zero result skips next word, two cycles
// RULE_12: Unlisted flags keep their values
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ccd_core #(
   parameter int unsigned STACK_DEPTH = 8
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic DOG_KICK
);
   import ccd_pkg::*;

   localparam int unsigned SP_W = $clog2(STACK_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check
   if (STACK_DEPTH < 2 || STACK_DEPTH != (1 << SP_W) || STACK_DEPTH > 256) begin : g_depth_bad
      $error("STACK_DEPTH must be a power of two from 2 to 256");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State of the core
   typedef struct packed {
      ccd_state_e state;
      logic [7:0] acc;
      logic [ST_W-1:0] status;
      logic [PC_W-1:0] pc;
      logic [LATCH_W-1:0] latch;
      logic [F_W-1:0] faddr;
      logic [PC_W-1:0] stack_head;
      logic [SP_W-1:0] sp;
      logic [7:0] wdt;
      logic [7:0] presc;
      logic [127:0][7:0] mem;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic kick;
   } ccd_core_s;

   ccd_core_s r;
   ccd_core_s next_r;

   logic access;
   logic wr;
   logic exec;
   ccd_op_e op;
   logic [F_W-1:0] f;
   logic dest_file;
   logic [K_W-1:0] k;
   logic mapped;
   logic [31:0] rd_val;

   ccd_alu_if alu_bus ();

   ////////////////////////////////////////////////////////////////////////////
   // Instruction word decode
   function automatic ccd_op_e decode(input logic [13:0] w);
      ccd_op_e res;
      res = OP_NOP;
      if (w == OPC_KICK) begin
         res = OP_KICK;
      end else if (w[13:11] == OPC_CALL_HI) begin
         res = OP_CALL;
      end else if (w[13:7] == OPC_ZFILE_HI) begin
         res = OP_ZFILE;
      end else if (w[13:7] == OPC_ZACC_HI) begin
         res = OP_ZACC;
      end else if (w[13:8] == OPC_INV_HI) begin
         res = OP_INV;
      end else if (w[13:8] == OPC_DEC_HI) begin
         res = OP_DEC;
      end else if (w[13:8] == OPC_DSKIP_HI) begin
         res = OP_DSKIP;
      end
      return res;
   endfunction

   // Bus phase and instruction fields
   assign access = PSEL && PENABLE;
   assign wr = access && r.pready && PWRITE;
   assign exec = wr && (PADDR == OFF_INSTR);
   assign op = decode(PWDATA[13:0]);
   assign f = PWDATA[F_W-1:0];
   assign dest_file = PWDATA[D_BIT];
   assign k = PWDATA[K_W-1:0];

   // Operand to the arithmetic unit
   assign alu_bus.kind = exec ? op : OP_NOP;
   assign alu_bus.operand = r.mem[f];

   ccd_alu u_alu (
      .bus(alu_bus.alu)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer and address decode
   always_comb begin
      rd_val = 32'h0000_0000;
      mapped = 1'b1;
      case (PADDR)
         OFF_INSTR: rd_val[0] = (r.state == ST_BUBBLE);
         OFF_ACC: rd_val[7:0] = r.acc;
         OFF_STATUS: rd_val[ST_W-1:0] = r.status;
         OFF_PC: rd_val[PC_W-1:0] = r.pc;
         OFF_LATCH: rd_val[LATCH_W-1:0] = r.latch;
         OFF_FADDR: rd_val[F_W-1:0] = r.faddr;
         OFF_FDATA: rd_val[7:0] = r.mem[r.faddr];
         OFF_STACK: begin
            rd_val[PC_W-1:0] = r.stack_head;
            rd_val[STACK_SP_LSB +: SP_W] = r.sp;
         end
         OFF_WDT: begin
            rd_val[7:0] = r.wdt;
            rd_val[WDT_PRESC_LSB +: 8] = r.presc;
         end
         default: mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r = r; // RULE_12
      next_r.kick = 1'b0;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      // Watchdog count with prescaler
      next_r.presc = r.presc + 8'h01;
      if (r.presc == PRESC_MAX) begin
         next_r.wdt = r.wdt + 8'h01;
      end
      // Bubble cycle of a two-cycle instruction
      if (r.state == ST_BUBBLE) begin
         next_r.state = ST_RUN;
      end
      // APB access phase answered one cycle later
      if (access && !r.pready) begin
         next_r.pready = 1'b1;
         next_r.pslverr = !mapped;
         next_r.prdata = PWRITE ? 32'h0000_0000 : rd_val;
      end
      // Register writes
      if (wr) begin
         case (PADDR)
            OFF_ACC: next_r.acc = PWDATA[7:0];
            OFF_STATUS: next_r.status = PWDATA[ST_W-1:0];
            OFF_PC: next_r.pc = PWDATA[PC_W-1:0];
            OFF_LATCH: next_r.latch = PWDATA[LATCH_W-1:0];
            OFF_FADDR: next_r.faddr = PWDATA[F_W-1:0];
            OFF_FDATA: next_r.mem[r.faddr] = PWDATA[7:0];
            default: ;
         endcase
      end
      // Instruction execution
      if (exec) begin
         next_r.pc = r.pc + 13'h0001;
         case (op)
            OP_KICK: begin
               next_r.wdt = 8'h00; // RULE_01
               next_r.presc = 8'h00; // RULE_01
               next_r.status[ST_DOG_EXPIRY] = 1'b1; // RULE_02
               next_r.status[ST_POWER_DOWN] = 1'b1; // RULE_02
               next_r.kick = 1'b1;
            end
            OP_CALL: begin
               next_r.stack_head = r.pc + 13'h0001; // RULE_03
               next_r.sp = r.sp + {{(SP_W-1){1'b0}}, 1'b1}; // RULE_03
               next_r.pc = {r.latch[LATCH_HI:LATCH_LO], k}; // RULE_04 RULE_05
               next_r.state = ST_BUBBLE; // RULE_05
            end
            OP_INV, OP_DEC: begin
               if (dest_file) begin
                  next_r.mem[f] = alu_bus.result; // RULE_06 RULE_09
               end else begin
                  next_r.acc = alu_bus.result; // RULE_06 RULE_09
               end
               next_r.status[ST_Z] = alu_bus.zero; // RULE_06 RULE_09
            end
            OP_DSKIP: begin
               if (dest_file) begin
                  next_r.mem[f] = alu_bus.result; // RULE_10
               end else begin
                  next_r.acc = alu_bus.result; // RULE_10
               end
               if (alu_bus.zero) begin
                  next_r.pc = r.pc + 13'h0002; // RULE_11
                  next_r.state = ST_BUBBLE; // RULE_11
               end
            end
            OP_ZFILE: begin
               next_r.mem[f] = 8'h00; // RULE_07
               next_r.status[ST_Z] = 1'b1; // RULE_07
            end
            OP_ZACC: begin
               next_r.acc = 8'h00; // RULE_08
               next_r.status[ST_Z] = 1'b1; // RULE_08
            end
            default: ;
         endcase
      end
      // Synchronous reset
      if (RST) begin
         next_r = '0;
         next_r.state = ST_RUN;
         next_r.status = STATUS_RST;
         next_r.pc = PC_RST;
      end
   end

   // State register
   always_ff @(posedge SYS_CLK) begin
      r <= next_r;
   end

   // Outputs straight from state
   assign PRDATA = r.prdata;
   assign PREADY = r.pready;
   assign PSLVERR = r.pslverr;
   assign DOG_KICK = r.kick;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_kick_clears: assert property (exec && op == OP_KICK |=> // RULE_01
      r.wdt == 8'h00 && r.presc == 8'h00 && DOG_KICK)
      else $error("kick did not clear watchdog");
   a_kick_flags: assert property (exec && op == OP_KICK |=> // RULE_02
      r.status[ST_DOG_EXPIRY] && r.status[ST_POWER_DOWN])
      else $error("kick did not set flags");
   a_call_push: assert property (exec && op == OP_CALL |=> // RULE_03
      r.stack_head == $past(r.pc) + 13'h0001 && r.sp == $past(r.sp) + 1'b1)
      else $error("call return address wrong");
   a_call_target: assert property (exec && op == OP_CALL |=> // RULE_04
      r.pc[K_W-1:0] == $past(PWDATA[K_W-1:0]))
      else $error("call low target wrong");
   a_call_page: assert property (exec && op == OP_CALL |=> // RULE_05
      r.pc[PC_W-1:K_W] == $past(r.latch[LATCH_HI:LATCH_LO])
      ##0 r.state == ST_BUBBLE ##1 r.state == ST_RUN)
      else $error("call page or timing wrong");
   a_invert_route: assert property (exec && op == OP_INV && !dest_file |=> // RULE_06
      r.acc == ~$past(r.mem[f]) && r.status[ST_Z] == (r.acc == 8'h00))
      else $error("invert to accumulator wrong");
   a_zero_file: assert property (exec && op == OP_ZFILE |=> // RULE_07
      r.mem[$past(f)] == 8'h00 && r.status[ST_Z])
      else $error("zero file wrong");
   a_zero_acc: assert property (exec && op == OP_ZACC |=> // RULE_08
      r.acc == 8'h00 && r.status[ST_Z])
      else $error("zero accumulator wrong");
   a_dec_file: assert property (exec && op == OP_DEC && dest_file |=> // RULE_09
      r.mem[$past(f)] == $past(r.mem[f]) - 8'h01
      && r.status[ST_Z] == (r.mem[$past(f)] == 8'h00))
      else $error("decrement to file wrong");
   a_skip_flags: assert property (exec && op == OP_DSKIP |=> // RULE_10
      r.status == $past(r.status))
      else $error("decrement-skip touched flags");
   a_skip_bubble: assert property (exec && op == OP_DSKIP && alu_bus.zero |=> // RULE_11
      r.pc == $past(r.pc) + 13'h0002 && r.state == ST_BUBBLE ##1 r.state == ST_RUN)
      else $error("skip not taken");
   a_skip_none: assert property (exec && op == OP_DSKIP && !alu_bus.zero |=> // RULE_11
      r.pc == $past(r.pc) + 13'h0001 && r.state == ST_RUN)
      else $error("skip taken wrongly");
   a_carry_kept: assert property (exec |=> // RULE_12
      r.status[ST_DC:ST_C] == $past(r.status[ST_DC:ST_C]))
      else $error("carry flags changed");
   a_invert_file: assert property (exec && op == OP_INV && dest_file |=> // RULE_06
      r.mem[$past(f)] == ~$past(r.mem[f]) && r.status[ST_Z] == (r.mem[$past(f)] == 8'h00))
      else $error("invert to file wrong");
   a_dec_acc: assert property (exec && op == OP_DEC && !dest_file |=> // RULE_09
      r.acc == $past(r.mem[f]) - 8'h01 && r.status[ST_Z] == (r.acc == 8'h00))
      else $error("decrement to accumulator wrong");
   a_skip_acc: assert property (exec && op == OP_DSKIP && !dest_file |=> // RULE_10
      r.acc == $past(r.mem[f]) - 8'h01 && r.mem[$past(f)] == $past(r.mem[f]))
      else $error("decrement-skip to accumulator wrong");
   a_skip_file: assert property (exec && op == OP_DSKIP && dest_file |=> // RULE_10
      r.mem[$past(f)] == $past(r.mem[f]) - 8'h01 && r.acc == $past(r.acc))
      else $error("decrement-skip to file wrong");
endmodule
`default_nettype wire

// ### tb/cpu_instr_clear_call_decrement_tb_top.sv
// Self-checking bench for the clear, call and decrement execution core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
   begin \
      tests_run++; \
      if ((a) !== (b)) begin \
         n_fail++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end
module cpu_instr_clear_call_decrement_tb_top;
   import ccd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // One instruction case: preset state and expected results
   typedef struct {
      logic [13:0] ins;
      logic [7:0] fv;
      logic [7:0] acc;
      logic [4:0] st;
      logic [7:0] eacc;
      logic [7:0] ef;
      logic [4:0] est;
      logic [12:0] epc;
   } ccd_row_s;

   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic DOG_KICK;
   int n_fail = 0;
   int tests_run = 0;
   int kicks = 0;
   ccd_row_s rows [10];

   // Clock at 100 MHz
   always #5 SYS_CLK = ~SYS_CLK;

   ccd_core #(.STACK_DEPTH(8)) u_ccd_core (
      .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .DOG_KICK(DOG_KICK)
   );

   // Watchdog pulse counter
   always @(posedge SYS_CLK) begin
      if (DOG_KICK === 1'b1) kicks++;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB transfer: hold request until PREADY sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask

   // Counts, verdict and end of run
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      n_fail++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      logic e;
      rows[0] = '{14'h0905, 8'h5A, 8'h11, 5'h03, 8'hA5, 8'h5A, 5'h03, 13'h1};
      rows[1] = '{14'h09FF, 8'hFF, 8'h33, 5'h03, 8'h33, 8'h00, 5'h07, 13'h1};
      rows[2] = '{14'h0185, 8'h77, 8'h44, 5'h00, 8'h44, 8'h00, 5'h04, 13'h1};
      rows[3] = '{14'h0100, 8'h12, 8'h99, 5'h03, 8'h00, 8'h12, 5'h07, 13'h1};
      rows[4] = '{14'h0305, 8'h01, 8'h55, 5'h03, 8'h00, 8'h01, 5'h07, 13'h1};
      rows[5] = '{14'h0385, 8'h00, 8'h55, 5'h07, 8'h55, 8'hFF, 5'h03, 13'h1};
      rows[6] = '{14'h0B85, 8'h05, 8'h22, 5'h04, 8'h22, 8'h04, 5'h04, 13'h1};
      rows[7] = '{14'h0B05, 8'h01, 8'h66, 5'h03, 8'h00, 8'h01, 5'h03, 13'h2};
      rows[8] = '{14'h0064, 8'h3C, 8'h21, 5'h03, 8'h21, 8'h3C, 5'h1B, 13'h1};
      rows[9] = '{14'h3FFF, 8'h6E, 8'h19, 5'h03, 8'h19, 8'h6E, 5'h03, 13'h1};
      repeat (16) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      // Reset values and an unmapped address
      rd(OFF_STATUS, r);
      `CHK(r, 32'h18)
      apb(1'b0, 8'h24, 32'h0, r, e);
      `CHK({e, r}, 33'h1_0000_0000)
      $display("reset test done");
      // Table of ordinary cases
      foreach (rows[i]) begin
         wr(OFF_FADDR, {25'h0, rows[i].ins[6:0]});
         wr(OFF_FDATA, {24'h0, rows[i].fv});
         wr(OFF_ACC, {24'h0, rows[i].acc});
         wr(OFF_STATUS, {27'h0, rows[i].st});
         wr(OFF_PC, 32'h0);
         wr(OFF_INSTR, {18'h0, rows[i].ins});
         rd(OFF_ACC, r);
         `CHK(r, {24'h0, rows[i].eacc})
         rd(OFF_FDATA, r);
         `CHK(r, {24'h0, rows[i].ef})
         rd(OFF_STATUS, r);
         `CHK(r, {27'h0, rows[i].est})
         rd(OFF_PC, r);
         `CHK(r, {19'h0, rows[i].epc})
         $display("row %0d done", i);
      end
      // Call at the top of the target range, latch low bits must not leak
      wr(OFF_LATCH, 32'h17);
      wr(OFF_PC, 32'h0123);
      wr(OFF_INSTR, 32'h27FF);
      rd(OFF_PC, r);
      `CHK(r, 32'h17FF)
      rd(OFF_STACK, r);
      `CHK(r[12:0], 13'h0124)
      $display("call test done");
      // Kick after the watchdog has advanced
      repeat (600) @(posedge SYS_CLK);
      wr(OFF_INSTR, 32'h0064);
      rd(OFF_WDT, r);
      `CHK(r[7:0], 8'h00)
      `CHK(r[15:8] < 8'h08, 1'b1)
      `CHK(kicks, 2)
      $display("kick test done");
      // Reset in mid-run
      wr(OFF_STATUS, 32'h03);
      RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      rd(OFF_STATUS, r);
      `CHK(r, 32'h18)
      rd(OFF_PC, r);
      `CHK(r, 32'h0)
      $display("second reset test done");
      conclude();
   end
endmodule
`default_nettype wire
